// [bench/lcc_cluster_properties.sv]
// Port-level properties of the logic cluster
`timescale 1ns/10ps
module lcc_cluster_properties #(
    parameter int N_CELLS = 10 // Cells per cluster
)
(
    input wire logic                    clock,             // Clock
    input wire logic                    rst_b,             // Reset
    input wire logic [3:0]              addr,              // Address
    input wire logic [31:0]             wr_data,           // Write data
    input wire logic                    wr_stb,            // Write strobe
    input wire logic                    rd_stb,            // Read strobe
    input wire logic [31:0]             rd_data,           // Read data
    input wire logic [1:0]              clk_ena,           // Enables
    input wire logic [1:0]              aclr,              // Async clears
    input wire logic                    aload,             // Async load
    input wire logic                    chip_wide_clear_n, // Chip clear
    input wire logic [N_CELLS-1:0][3:0] cell_data,         // Cell inputs
    input wire logic [N_CELLS-1:0]      route_a_out,       // Row/col out
    input wire logic [N_CELLS-1:0]      route_b_out,       // Direct out
    input wire logic [N_CELLS-1:0]      local_out          // Local out
);
    logic [31:0] shadow_q [0:10];
    logic [31:0] exp_q;
    logic        chk_q;
    logic [2:0]  sel0;

    assign sel0 = shadow_q[0][22:20];

    // Shadow of the config words, masked to their implemented bits
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            shadow_q <= '{default: 32'h0};
            exp_q    <= 32'h0;
            chk_q    <= 1'b0;
        end
        else
        begin
            if (wr_stb && addr <= 4'hA)
                shadow_q[addr] <= wr_data & ((addr == 4'hA) ? 32'h1FF : 32'hFFFFFFF);
            chk_q <= rd_stb && addr <= 4'hA;
            exp_q <= shadow_q[addr];
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    sequence s_quiet;
        aclr == 2'h0 && !aload && chip_wide_clear_n && !wr_stb;
    endsequence
    sequence s_off;
        (clk_ena == 2'h0 && sel0[1]) and s_quiet;
    endsequence
    sequence s_chip;
        shadow_q[10][8] && !chip_wide_clear_n && sel0[1];
    endsequence

    property p_rd_idle;
        !$past(rd_stb) |-> rd_data == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    property p_rd_unmapped;
        rd_stb && addr > 4'hD |=> rd_data == 32'h0;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
    property p_readback;
        chk_q |-> rd_data == exp_q;
    endproperty
    a_readback: assert property (p_readback) else $error("config readback wrong");
    property p_aclr_wins;
        sel0[1] && aclr == 2'h3 && aload |-> route_b_out[0] == 1'b0;
    endproperty
    a_aclr_wins: assert property (p_aclr_wins) else $error("clear lost to load");
    property p_aload;
        sel0[1] && aclr == 2'h0 && aload && chip_wide_clear_n
            |-> route_b_out[0] == cell_data[0][3];
    endproperty
    a_aload: assert property (p_aload) else $error("async load value wrong");
    property p_chip_clr;
        s_chip ##1 s_chip |-> route_b_out[0] == 1'b0;
    endproperty
    a_chip_clr: assert property (p_chip_clr) else $error("chip clear ignored");
    property p_hold;
        s_off ##1 s_off ##1 s_quiet |-> $stable(route_b_out[0]);
    endproperty
    a_hold: assert property (p_hold) else $error("register moved while gated");
    property p_pack;
        sel0[0] == sel0[2] |-> route_a_out[0] == local_out[0];
    endproperty
    a_pack: assert property (p_pack) else $error("output select mismatch");
endmodule

// [bench/lcc_cluster_tb.sv]
// Self-checking bench for the logic cluster
`timescale 1ns/10ps
module lcc_cluster_tb;
    localparam logic [15:0] MASK = 16'h6996;
    localparam logic [6:0]  FF_TAB [4] = '{7'h23, 7'h50, 7'h70, 7'h63};
    localparam logic [6:0]  AR_TAB [6] = '{7'h01, 7'h20, 7'h12, 7'h46, 7'h51, 7'h7E};
    logic            clock, rst_b, wr_stb, rd_stb, aload, sclr, sload, addnsub;
    logic            chip_wide_clear_n, lab_cin, cz_in, co_in, reg_chain_in, go;
    logic [3:0]      addr;
    logic [31:0]     wr_data, rd_data;
    logic [5:0]      row_clk;
    logic [1:0]      local_clk, clk_ena, aclr;
    logic [9:0][3:0] cell_data;
    logic [9:0]      ra, rb, lo;
    logic            czo, coo, lco, rco;
    logic [2:0]      sel;
    int              fail_count, total_checks, cyc;

    lcc_cluster #(.N_CELLS(10)) u_dut (.clock, .rst_b, .addr, .wr_data, .wr_stb,
        .rd_stb, .rd_data, .row_clk, .local_clk, .clk_ena, .aclr, .aload, .sclr,
        .sload, .addnsub, .chip_wide_clear_n, .cell_data, .lab_cin,
        .carry_chain_zero_in(cz_in), .carry_chain_one_in(co_in), .reg_chain_in,
        .route_a_out(ra), .route_b_out(rb), .local_out(lo), .carry_chain_zero_out(czo),
        .carry_chain_one_out(coo), .lut_chain_out(lco), .reg_chain_out(rco));
    lcc_fabric_model u_fabric (.clock, .rst_b, .go, .sel, .row_clk);

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        addr <= a;
        wr_data <= d;
        wr_stb <= 1'b1;
        @(posedge clock);
        wr_stb <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clock);
        rd_stb <= 1'b0;
        @(posedge clock);
        check(rd_data, e);
    endtask
    function automatic logic [31:0] cc(input logic [2:0] o, input logic [15:0] m,
                                       input logic [3:0] h, input logic [1:0] f);
        return {4'h0, h, 1'b0, o, 2'h0, f, m};
    endfunction
    // Outputs are read at the edge, so they show the cycle just ended
    task automatic tick(input logic [3:0] d, input logic e);
        cell_data[0] <= d;
        go <= 1'b1;
        @(posedge clock);
        go <= 1'b0;
        repeat (6) @(posedge clock);
        check(rb[0], e);
    endtask
    task automatic hold(input logic [3:0] d, input logic e);
        cell_data[0] <= d;
        repeat (2) @(posedge clock);
        check(rb[0], e);
    endtask
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    always @(posedge clock)
    begin
        cyc++;
        if (cyc > 3000)
        begin
            fail_count++;
            summarize();
        end
    end

    initial
    begin
        {wr_stb, rd_stb, aload, sclr, sload, addnsub, lab_cin, cz_in, co_in} = '0;
        {reg_chain_in, go, rst_b, addr, wr_data, local_clk, clk_ena, aclr} = '0;
        cell_data = '0;
        sel = 3'h0;
        chip_wide_clear_n = 1'b1;
        fail_count = 0;
        total_checks = 0;
        cyc = 0;
        repeat (20) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        rd(4'h0, 32'h0);
        rd(4'hA, 32'h0);
        wr(4'h0, 32'hFFFFFFFF);
        rd(4'h0, 32'h0FFFFFFF);
        wr(4'hA, 32'hFFFFFFFF);
        rd(4'hA, 32'h000001FF);
        wr(4'hF, 32'hFFFFFFFF);
        rd(4'hF, 32'h0);
        wr(4'hA, 32'h0);
        wr(4'h0, cc(3'h0, MASK, 4'h0, 2'h0));
        wr(4'h1, cc(3'h0, 16'hAAAA, 4'h4, 2'h0));
        wr(4'h9, cc(3'h0, MASK, 4'h0, 2'h0));
        for (int i = 0; i < 16; i++)
        begin
            cell_data[0] <= 4'(i);
            cell_data[9] <= 4'(i);
            repeat (2) @(posedge clock);
            check({lco, ra[1:0], rb[0], lo[0]}, {5{MASK[i]}});
        end
        // Last cell keeps a high async data bit for the chain output checks
        cell_data[9] <= 4'h8;
        wr(4'h0, cc(3'h2, MASK, 4'h0, 2'h0));
        clk_ena <= 2'h1;
        for (int s = 0; s < 6; s += 5)
        begin
            wr(4'hA, 32'(s));
            sel <= 3'(s);
            tick(4'h1, 1'b1);
            tick(4'h0, 1'b0);
        end
        // Falling edge of local line 0: the rising edge must not load
        wr(4'hA, 32'h46);
        cell_data[0] <= 4'h1;
        local_clk <= 2'h1;
        repeat (3) @(posedge clock);
        check(rb[0], 1'b0);
        local_clk <= 2'h0;
        repeat (2) @(posedge clock);
        check(rb[0], 1'b1);
        wr(4'hA, 32'h5);
        tick(4'h1, 1'b1);
        hold(4'h0, 1'b1);
        check({ra[0], rb[0]}, 32'h1);
        clk_ena <= 2'h2;
        tick(4'h0, 1'b1);
        clk_ena <= 2'h1;
        sclr <= 1'b1;
        sload <= 1'b1;
        tick(4'h9, 1'b0);
        sclr <= 1'b0;
        tick(4'h9, 1'b1);
        sclr <= 1'b1;
        sload <= 1'b0;
        clk_ena <= 2'h0;
        tick(4'h0, 1'b1);
        sclr <= 1'b0;
        clk_ena <= 2'h1;
        aclr <= 2'h1;
        hold(4'h8, 1'b0);
        aclr <= 2'h0;
        aload <= 1'b1;
        hold(4'h8, 1'b1);
        check(rco, 1'b1);
        aclr <= 2'h3;
        hold(4'h8, 1'b0);
        check(rco, 1'b0);
        aclr <= 2'h0;
        hold(4'h8, 1'b1);
        aload <= 1'b0;
        chip_wide_clear_n <= 1'b0;
        hold(4'h0, 1'b1);
        wr(4'hA, 32'h105);
        hold(4'h0, 1'b0);
        chip_wide_clear_n <= 1'b1;
        wr(4'hA, 32'h5);
        wr(4'h0, cc(3'h2, MASK, 4'h8, 2'h0));
        for (int i = 1; i >= 0; i--)
        begin
            reg_chain_in <= 1'(i);
            tick(4'h0, 1'(i));
        end
        for (int m = 0; m < 4; m++)
        begin
            wr(4'h0, cc(3'h2, MASK, 4'h0, FF_TAB[m][6:5]));
            tick(FF_TAB[m][4:1], FF_TAB[m][0]);
        end
        wr(4'h0, cc(3'h0, 16'h0, 4'h1, 2'h0));
        cz_in <= 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            {addnsub, lab_cin} <= AR_TAB[i][6:5];
            cell_data[0] <= {2'h0, AR_TAB[i][4:3]};
            repeat (2) @(posedge clock);
            check({coo, czo, ra[0]}, AR_TAB[i][2:0]);
        end
        summarize();
    end
endmodule

bind lcc_cluster lcc_cluster_properties #(.N_CELLS(N_CELLS)) u_props (.clock, .rst_b,
    .addr, .wr_data, .wr_stb, .rd_stb, .rd_data, .clk_ena, .aclr, .aload,
    .chip_wide_clear_n, .cell_data, .route_a_out, .route_b_out, .local_out);

// [bench/lcc_fabric_model.sv]
// Row clock source standing in for the routing fabric
`timescale 1ns/10ps
module lcc_fabric_model #(
    parameter int HIGH_CYC = 3 // Cycles a row clock stays high
)
(
    input  wire logic       clock,   // Clock
    input  wire logic       rst_b,   // Reset
    input  wire logic       go,      // Start one pulse
    input  wire logic [2:0] sel,     // Row clock to pulse
    output logic      [5:0] row_clk  // Row clocks
);
    logic [3:0] cnt_q;

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            cnt_q <= 4'h0;
        else if (go)
            cnt_q <= 4'(HIGH_CYC);
        else if (cnt_q != 4'h0)
            cnt_q <= cnt_q - 4'h1;
    end

    // Low between pulses so no stray edge reaches the cluster
    assign row_clk = (cnt_q != 4'h0) ? (6'h1 << sel) : 6'h0;
endmodule

// [design/lcc_cell.sv]
// One logic cell: look-up table and carry-select arithmetic
`timescale 1ns/10ps
module lcc_cell
(
    input  wire logic              [3:0] data,      // Four data inputs
    input  lcc_pkg::lcc_cell_cfg_t       cfg,       // Cell configuration
    input  wire logic                    chain_lut, // Previous cell table
    input  wire logic                    q_fb,      // Own register output
    input  wire logic                    cin0,      // Chain assuming 0
    input  wire logic                    cin1,      // Chain assuming 1
    input  wire logic                    lab_cin,   // Cluster carry-in
    input  wire logic                    addnsub,   // 1 = subtract
    output logic                         lut_out,   // Table or sum
    output logic                         cout0,     // Carry for chain 0
    output logic                         cout1      // Carry for chain 1
);

    logic [3:0] idx;
    logic       b;

    always_comb
    begin
        b = data[1] ^ addnsub;
        idx[0] = cfg.chain_in ? chain_lut : data[0];
        idx[1] = data[1];
        idx[2] = cfg.reg_fb ? q_fb : data[2];
        idx[3] = cfg.cin_sel ? (lab_cin ? cin1 : cin0) : data[3];
        if (cfg.arith)
        begin
            // Both sums exist; the cluster carry-in picks one
            lut_out = data[0] ^ b ^ (lab_cin ? cin1 : cin0);
            cout0 = (data[0] & b) | (cin0 & (data[0] ^ b));
            cout1 = (data[0] & b) | (cin1 & (data[0] ^ b));
        end
        else
        begin
            lut_out = cfg.lut_mask[idx];
            cout0 = cin0;
            cout1 = cin1;
        end
    end

endmodule

// [design/lcc_cluster.sv]
// Logic cluster of ten cells with shared controls and a config port
//
// How it works
// - Ten cells, chains, controls, local interconnect
// - Table output feeds next cell's table
// - Register output shifts into next register
// - At most ten cluster control signals
// - Each clock uses its own enable
// - Both edges occupy both cluster clocks
// - Dropped enable freezes registers on clock
// - Async load takes async data; preset
// - Controls from six row clocks, local
// - Four-input table realises any function
// - Register acts as D, T, JK, SR
// - Async load data is fourth input
// - Combinational path bypasses the register
// - Three outputs, each table or register
// - Register may feed own table
// - Registered and unregistered outputs together
// - Subtract inverts B, carry-in one
// - First cell forces carry-in when subtracting
// - Normal or arithmetic mode per cell
// - Controls usable in all modes
// - Normal mode: carry or fourth input
// - Outputs reach thirty cells via local
// - Async clear beats async load
// - Chip-wide clear overrides everything
// - Cluster carry-in selects precomputed chain
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/10ps
module lcc_cluster #(
    parameter int N_CELLS = lcc_pkg::N_CELLS // Cells per cluster
)
(
    input  wire logic                      clock,           // 50 MHz clock
    input  wire logic                      rst_b,           // Async reset
    input  wire logic [3:0]                addr,            // Config address
    input  wire logic [31:0]               wr_data,         // Write data
    input  wire logic                      wr_stb,          // Write strobe
    input  wire logic                      rd_stb,          // Read strobe
    output logic      [31:0]               rd_data,         // Read data
    input  wire logic [5:0]                row_clk,         // Row clocks
    input  wire logic [1:0]                local_clk,       // Local clocks
    input  wire logic [1:0]                clk_ena,         // Clock enables
    input  wire logic [1:0]                aclr,            // Async clears
    input  wire logic                      aload,           // Async load
    input  wire logic                      sclr,            // Sync clear
    input  wire logic                      sload,           // Sync load
    input  wire logic                      addnsub,         // 1 = subtract
    input  wire logic                      chip_wide_clear_n, // Chip clear
    input  wire logic [N_CELLS-1:0][3:0]   cell_data,       // Cell inputs
    input  wire logic                      lab_cin,         // Cluster carry
    input  wire logic                      carry_chain_zero_in, // Chain 0
    input  wire logic                      carry_chain_one_in,  // Chain 1
    input  wire logic                      reg_chain_in,    // Shift input
    output logic      [N_CELLS-1:0]        route_a_out,     // Row/col out
    output logic      [N_CELLS-1:0]        route_b_out,     // Direct link
    output logic      [N_CELLS-1:0]        local_out,       // Local out
    output logic                           carry_chain_zero_out, // Chain 0
    output logic                           carry_chain_one_out,  // Chain 1
    output logic                           lut_chain_out,   // Last table
    output logic                           reg_chain_out    // Last register
);

    typedef struct packed {
        lcc_pkg::lcc_cell_cfg_t [N_CELLS-1:0] cell_cfg;
        lcc_pkg::lcc_clu_cfg_t                clu_cfg;
        logic [N_CELLS-1:0]                   q;
        logic [31:0]                          rd;
    } lcc_cluster_st_t;

    lcc_cluster_st_t    st_q;
    lcc_cluster_st_t    st_d;
    logic [1:0]         clk_evt;
    logic [N_CELLS-1:0] lut;
    logic [N_CELLS-1:0] q_eff;
    logic [N_CELLS-1:0] q_prev;
    logic [N_CELLS:0]   c0;
    logic [N_CELLS:0]   c1;
    logic [N_CELLS:0]   lchain;
    logic               chip_clr;

    // Next state of a configurable register from its two drive terms
    function automatic logic ff_next(input lcc_pkg::lcc_ff_mode_t m,
                                     input logic q, input logic a,
                                     input logic b);
        case (m)
            lcc_pkg::LCC_FF_D:  return a;
            lcc_pkg::LCC_FF_T:  return q ^ a;
            lcc_pkg::LCC_FF_JK: return (a & ~q) | (~b & q);
            default:            return ~b & (a | q); // Reset wins in SR
        endcase
    endfunction

    // Async override as the outside sees it, before the next edge lands
    function automatic logic async_q(input logic clr, input logic ac,
                                     input logic al, input logic d3,
                                     input logic q);
        if (clr)
            return 1'b0;
        if (ac)
            return 1'b0;
        if (al)
            return d3;
        return q;
    endfunction

    lcc_ctrl u_ctrl
    (
        .clock     (clock),
        .rst_b     (rst_b),
        .row_clk   (row_clk),
        .local_clk (local_clk),
        .clk_ena   (clk_ena),
        .cfg       (st_q.clu_cfg),
        .clk_evt   (clk_evt)
    );

    assign chip_clr = st_q.clu_cfg.chip_clr_en & ~chip_wide_clear_n;

    // First cell: subtraction forces both chains to carry one
    assign c0[0] = addnsub ? 1'b1 : carry_chain_zero_in;
    assign c1[0] = addnsub ? 1'b1 : carry_chain_one_in;
    assign lchain[0] = 1'b0;
    // Shift source per cell, so no index ever falls below cell zero
    assign q_prev = {q_eff[N_CELLS-2:0], reg_chain_in};

    genvar gi;
    generate
        for (gi = 0; gi < N_CELLS; gi++)
        begin : g_cell
            assign q_eff[gi] = async_q(chip_clr,
                                       aclr[st_q.cell_cfg[gi].aclr_sel],
                                       aload, cell_data[gi][3], st_q.q[gi]);

            lcc_cell u_cell
            (
                .data      (cell_data[gi]),
                .cfg       (st_q.cell_cfg[gi]),
                .chain_lut (lchain[gi]),
                .q_fb      (q_eff[gi]),
                .cin0      (c0[gi]),
                .cin1      (c1[gi]),
                .lab_cin   (lab_cin | addnsub),
                .addnsub   (addnsub & st_q.cell_cfg[gi].arith),
                .lut_out   (lut[gi]),
                .cout0     (c0[gi+1]),
                .cout1     (c1[gi+1])
            );

            assign lchain[gi+1] = lut[gi];
        end
    endgenerate

    always_comb
    begin
        st_d = st_q;
        st_d.rd = '0;

        // Configuration port: writes land at once, reads one cycle later
        if (wr_stb)
        begin
            if (addr < 4'(N_CELLS))
                st_d.cell_cfg[addr] = wr_data[lcc_pkg::CELL_CFG_W-1:0];
            else if (addr == lcc_pkg::CLU_CFG_ADDR)
                st_d.clu_cfg = wr_data[lcc_pkg::CLU_CFG_W-1:0];
        end
        if (rd_stb)
        begin
            if (addr < 4'(N_CELLS))
                st_d.rd = {{(32-lcc_pkg::CELL_CFG_W){1'b0}}, st_q.cell_cfg[addr]};
            else if (addr == lcc_pkg::CLU_CFG_ADDR)
                st_d.rd = {{(32-lcc_pkg::CLU_CFG_W){1'b0}}, st_q.clu_cfg};
            else if (addr == lcc_pkg::REG_STATE_ADDR)
                st_d.rd = {{(32-N_CELLS){1'b0}}, q_eff};
            else if (addr == lcc_pkg::LUT_STATE_ADDR)
                st_d.rd = {{(32-N_CELLS){1'b0}}, lut};
            else if (addr == lcc_pkg::CTL_STATE_ADDR)
                // Snapshot of the ten cluster control lines
                st_d.rd = {22'h000000, addnsub, sload, aload, sclr,
                           aclr, clk_ena, clk_evt};
            else
                st_d.rd = '0;
        end

        for (int i = 0; i < N_CELLS; i++)
        begin
            if (chip_clr)
                st_d.q[i] = 1'b0;
            else if (aclr[st_q.cell_cfg[i].aclr_sel])
                st_d.q[i] = 1'b0;
            else if (aload)
                st_d.q[i] = cell_data[i][3];
            else if (clk_evt[st_q.cell_cfg[i].clk_sel])
            begin
                if (sclr)
                    st_d.q[i] = 1'b0;
                else if (sload)
                    st_d.q[i] = cell_data[i][3];
                else if (st_q.cell_cfg[i].reg_chain)
                    st_d.q[i] = q_prev[i];
                else
                    st_d.q[i] = ff_next(st_q.cell_cfg[i].ff_mode, q_eff[i],
                                        lut[i], cell_data[i][3]);
            end
        end
    end

    // Each output picks table or register on its own, so both can leave
    always_comb
    begin
        for (int i = 0; i < N_CELLS; i++)
        begin
            route_a_out[i] = st_q.cell_cfg[i].out_sel[0] ? q_eff[i] : lut[i];
            route_b_out[i] = st_q.cell_cfg[i].out_sel[1] ? q_eff[i] : lut[i];
            // Local line fans out to this and both neighbour clusters
            local_out[i] = st_q.cell_cfg[i].out_sel[2] ? q_eff[i] : lut[i];
        end
    end

    assign carry_chain_zero_out = c0[N_CELLS];
    assign carry_chain_one_out  = c1[N_CELLS];
    assign lut_chain_out        = lut[N_CELLS-1];
    assign reg_chain_out        = q_eff[N_CELLS-1];
    assign rd_data              = st_q.rd;

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_q.cell_cfg <= {N_CELLS{lcc_pkg::CELL_CFG_RST}};
            st_q.clu_cfg  <= lcc_pkg::CLU_CFG_RST;
            st_q.q        <= '0;
            st_q.rd       <= '0;
        end
        else
            st_q <= st_d;
    end

endmodule

// [design/lcc_ctrl.sv]
// Cluster-wide clock event generation from row clocks and local lines
`timescale 1ns/10ps
module lcc_ctrl
(
    input  wire logic                clock,     // System clock
    input  wire logic                rst_b,     // Async reset, active low
    input  wire logic [5:0]          row_clk,   // Row clocks, sampled
    input  wire logic [1:0]          local_clk, // Clocks from local lines
    input  wire logic [1:0]          clk_ena,   // Paired clock enables
    input  lcc_pkg::lcc_clu_cfg_t    cfg,       // Source and edge choice
    output logic [1:0]               clk_evt    // Gated edge pulses
);

    typedef struct packed {
        logic [1:0] prev;
    } lcc_ctrl_st_t;

    lcc_ctrl_st_t st_q;
    lcc_ctrl_st_t st_d;
    logic [1:0]   lvl;

    // Any of the six row clocks or a local interconnect line
    function automatic logic pick(input logic [2:0] src, input logic [5:0] rc,
                                  input logic loc);
        if (src >= lcc_pkg::CLK_SRC_LOCAL)
            return loc;
        return rc[src];
    endfunction

    always_comb
    begin
        st_d = st_q;
        lvl[0] = pick(cfg.clk_src0, row_clk, local_clk[0]);
        lvl[1] = pick(cfg.clk_src1, row_clk, local_clk[1]);
        st_d.prev = lvl;
        for (int k = 0; k < 2; k++)
        begin
            // Both edges of one source need both cluster clocks
            clk_evt[k] = (cfg.clk_fall[k] ? (st_q.prev[k] & ~lvl[k])
                                          : (~st_q.prev[k] & lvl[k]))
                         & clk_ena[k];
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            st_q <= '0;
        else
            st_q <= st_d;
    end

endmodule

// [design/lcc_pkg.sv]
// Constants and types shared by the logic cluster cell model
package lcc_pkg;

    localparam int N_CELLS  = 10;
    localparam int ROW_CLKS = 6;
    localparam int ADDR_W   = 4;
    localparam int DATA_W   = 32;

    // Register map, one word per address
    localparam logic [3:0] CELL_CFG_BASE = 4'h0;
    localparam logic [3:0] CLU_CFG_ADDR  = 4'hA;
    localparam logic [3:0] REG_STATE_ADDR = 4'hB;
    localparam logic [3:0] LUT_STATE_ADDR = 4'hC;
    localparam logic [3:0] CTL_STATE_ADDR = 4'hD;

    // Clock source code that picks the local interconnect clock
    localparam logic [2:0] CLK_SRC_LOCAL = 3'h6;

    // Register behaviour of a cell
    typedef enum logic [1:0]
    {
        LCC_FF_D  = 2'h0,
        LCC_FF_T  = 2'h1,
        LCC_FF_JK = 2'h2,
        LCC_FF_SR = 2'h3
    } lcc_ff_mode_t;

    // Per-cell configuration word, bits 27..0
    typedef struct packed {
        logic         reg_chain;
        logic         chain_in;
        logic         cin_sel;
        logic         arith;
        logic         reg_fb;
        logic [2:0]   out_sel;
        logic         aclr_sel;
        logic         clk_sel;
        lcc_ff_mode_t ff_mode;
        logic [15:0]  lut_mask;
    } lcc_cell_cfg_t;

    // Cluster configuration word, bits 8..0
    typedef struct packed {
        logic         chip_clr_en;
        logic [1:0]   clk_fall;
        logic [2:0]   clk_src1;
        logic [2:0]   clk_src0;
    } lcc_clu_cfg_t;

    localparam int CELL_CFG_W = $bits(lcc_cell_cfg_t);
    localparam int CLU_CFG_W  = $bits(lcc_clu_cfg_t);

    localparam lcc_cell_cfg_t CELL_CFG_RST = '0;
    localparam lcc_clu_cfg_t  CLU_CFG_RST  = '0;

endpackage
